// File: src/scd_ctrl.sv
// speaker mode, boost and switching clock control with apb registers
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RULE1] A high strap pin selects mono speaker operation and a grounded one selects stereo.
// [RULE2] The strap pull-up is on after reset and one control bit turns it off with 0 and on with 1.
// [RULE3] In mono the host sets both driver enables and only the left boost setting is applied.
// [RULE4] The left boost field sits at bits 5:3, codes 0 to 6 give 0 to 9 dB in 1.5 dB steps, 7 gives 12 dB, reset 0.
// [RULE5] The right boost field sits at bits 2:0 with the same coding and reset 0.
// [RULE6] The host changes boost fields only while both speaker outputs are disabled.
// [RULE7] The switching clock is divided from the system clock with a ratio taken from the rate settings alone.
// [RULE8] The switching clock runs whenever either driver enable is set; the code also requires clk_ok and rate_ok.
// [RULE9] Source select 0 takes the first interface's rate fields and 1 takes the second's.
// [RULE10] The host keeps the system clock and the chosen interface clock running while the outputs switch.
// [RULE11] A missing system clock is detected and then the speaker outputs are disabled.
// [RULE12] The 11.025 kHz family gives 352.8 kHz and the 12 kHz family gives 384 kHz at every ratio; the code gives none where fs*ratio exceeds 12.288 MHz.
// [RULE13] 16 and 32 kHz give 341.3 kHz at even ratios and 384 kHz at triple ratios; 8 kHz gives 341.3 or 256 kHz; code gives none above fs*ratio 12.288 MHz.
// [RULE14] The switching clock stops when both enables are clear or the clock has been lost.
module scd_ctrl import scd_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic speaker_mode_strap,
  input wire logic system_clock_tick,
  output logic mode_strap_pullup_en,
  output logic mono_mode,
  output logic [2:0] left_boost_gain,
  output logic [2:0] right_boost_gain,
  output logic left_output_en,
  output logic right_output_en,
  output logic switch_clk
);

  logic [2:0] lboost_reg, lboost_next;
  logic [2:0] rboost_reg, rboost_next;
  logic pullup_reg, pullup_next;
  logic [1:0] drv_en_reg, drv_en_next;
  logic src_reg, src_next;
  logic [3:0] sr1_reg, sr1_next, sr2_reg, sr2_next;
  logic [2:0] rt1_reg, rt1_next, rt2_reg, rt2_next;
  logic [31:0] prdata_reg, prdata_next;
  logic mono_reg, mono_next;
  logic [2:0] lg_out_reg, lg_out_next, rg_out_reg, rg_out_next;
  logic len_reg, len_next, ren_reg, ren_next;
  logic [7:0] gap_reg, gap_next;
  logic [11:0] idx;
  logic hit;
  logic wr_en;
  logic [31:0] rd_mux;
  logic [3:0] sel_sr;
  logic [2:0] sel_rt;
  logic [8:0] lut;
  scd_fsw_t fsw;
  logic [5:0] div_n;
  logic rate_ok;
  logic clk_ok;
  logic run;

  // divide ratio n = fs*ratio/fsw, from ratio/64 (m) and the rate family
  function automatic logic [8:0] rate_lookup(input logic [3:0] sr, input logic [2:0] rt);
    logic [5:0] m;
    logic [5:0] m3;
    logic trip;
    logic [2:0] top;
    scd_fsw_t f;
    logic [5:0] n;
    case (rt)
      3'h0: m = 6'h02;
      3'h1: m = 6'h03;
      3'h2: m = 6'h04;
      3'h3: m = 6'h06;
      3'h4: m = 6'h08;
      3'h5: m = 6'h0c;
      3'h6: m = 6'h10;
      default: m = 6'h18;
    endcase
    m3 = 6'(m / 6'h03);
    trip = rt[0];
    top = 3'h0;
    f = FSW_OFF;
    n = 6'h00;
    case (sr)
      SR_8K: begin
        top = 3'h7;
        if (!trip && rt != 3'h0) begin
          f = FSW_341K3;
          n = 6'(3 * (m >> 1));
        end else begin
          f = FSW_256K;
          n = 6'(2 * m);
        end
      end
      SR_11K025, SR_12K: begin
        top = 3'h6;
        f = (sr == SR_11K025) ? FSW_352K8 : FSW_384K;
        n = 6'(2 * m);
      end
      SR_16K: begin
        top = 3'h5;
        f = trip ? FSW_384K : FSW_341K3;
        n = trip ? 6'(8 * m3) : 6'(3 * m);
      end
      SR_22K05, SR_24K: begin
        top = 3'h4;
        f = (sr == SR_22K05) ? FSW_352K8 : FSW_384K;
        n = 6'(4 * m);
      end
      SR_32K: begin
        top = 3'h3;
        f = trip ? FSW_384K : FSW_341K3;
        n = trip ? 6'(16 * m3) : 6'(6 * m);
      end
      SR_44K1, SR_48K: begin
        top = 3'h2;
        f = (sr == SR_44K1) ? FSW_352K8 : FSW_384K;
        n = 6'(8 * m);
      end
      SR_88K2, SR_96K: begin
        top = 3'h0;
        f = (sr == SR_88K2) ? FSW_352K8 : FSW_384K;
        n = 6'(16 * m);
      end
      default: begin
        top = 3'h0;
        f = FSW_OFF;
        n = 6'h00;
      end
    endcase
    // combinations with no documented frequency leave the clock off
    if (rt > top || f == FSW_OFF) begin
      f = FSW_OFF;
      n = 6'h00;
    end
    return {f, n};
  endfunction

  // apb decode: word aligned, index in bits 13:2
  assign idx = paddr[13:2];
  always_comb begin
    hit = 1'b0;
    if (paddr[1:0] == 2'h0 && paddr[15:14] == 2'h0) begin
      case (idx)
        IDX_DRV_EN, IDX_CLK_SRC, IDX_STATUS, IDX_IF1_RATE, IDX_IF2_RATE, IDX_BOOST, IDX_PULL: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end
  assign wr_en = psel && penable && pwrite && hit && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_DRV_EN: rd_mux[1:0] = drv_en_reg;
      IDX_CLK_SRC: rd_mux[SRC_BIT] = src_reg;
      IDX_STATUS: rd_mux[6:0] = {fsw, run, rate_ok, clk_ok, mono_reg};
      IDX_IF1_RATE: rd_mux[6:0] = {rt1_reg, sr1_reg};
      IDX_IF2_RATE: rd_mux[6:0] = {rt2_reg, sr2_reg};
      IDX_BOOST: rd_mux[5:0] = {lboost_reg, rboost_reg};
      IDX_PULL: rd_mux[PU_BIT] = pullup_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (!hit) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // register file; read data captured in the setup cycle so it is a flop
  always_comb begin
    lboost_next = lboost_reg;
    rboost_next = rboost_reg;
    pullup_next = pullup_reg;
    drv_en_next = drv_en_reg;
    src_next = src_reg;
    sr1_next = sr1_reg;
    rt1_next = rt1_reg;
    sr2_next = sr2_reg;
    rt2_next = rt2_reg;
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      prdata_next = rd_mux;
    end
    if (wr_en) begin
      case (idx)
        IDX_BOOST: begin
          lboost_next = pwdata[LB_MSB:LB_LSB]; // RULE4
          rboost_next = pwdata[RB_MSB:RB_LSB]; // RULE5
        end
        IDX_PULL: pullup_next = pwdata[PU_BIT]; // RULE2
        IDX_DRV_EN: drv_en_next = {pwdata[REN_BIT], pwdata[LEN_BIT]};
        IDX_CLK_SRC: src_next = pwdata[SRC_BIT];
        IDX_IF1_RATE: begin
          sr1_next = pwdata[SR_MSB:SR_LSB];
          rt1_next = pwdata[RT_MSB:RT_LSB];
        end
        IDX_IF2_RATE: begin
          sr2_next = pwdata[SR_MSB:SR_LSB];
          rt2_next = pwdata[RT_MSB:RT_LSB];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lboost_reg <= BOOST_RST;
      rboost_reg <= BOOST_RST;
      pullup_reg <= PULL_RST;
      drv_en_reg <= DRV_EN_RST;
      src_reg <= SRC_RST;
      sr1_reg <= SR_RST;
      rt1_reg <= RT_RST;
      sr2_reg <= SR_RST;
      rt2_reg <= RT_RST;
      prdata_reg <= 32'h0000_0000;
    end else begin
      lboost_reg <= lboost_next;
      rboost_reg <= rboost_next;
      pullup_reg <= pullup_next;
      drv_en_reg <= drv_en_next;
      src_reg <= src_next;
      sr1_reg <= sr1_next;
      rt1_reg <= rt1_next;
      sr2_reg <= sr2_next;
      rt2_reg <= rt2_next;
      prdata_reg <= prdata_next;
    end
  end

  // rate source and divide ratio
  assign sel_sr = src_reg ? sr2_reg : sr1_reg; // RULE9
  assign sel_rt = src_reg ? rt2_reg : rt1_reg; // RULE9
  assign lut = rate_lookup(sel_sr, sel_rt); // RULE12 RULE13
  assign fsw = scd_fsw_t'(lut[8:6]);
  assign div_n = lut[5:0];
  assign rate_ok = (fsw != FSW_OFF);

  // clock presence: a gap of GAP_LIMIT cycles without a tick means lost
  always_comb begin
    gap_next = gap_reg;
    if (system_clock_tick) begin
      gap_next = 8'h00;
    end else if (gap_reg != GAP_LIMIT) begin
      gap_next = 8'(gap_reg + 8'h01);
    end
  end
  assign clk_ok = (gap_reg != GAP_LIMIT); // RULE11
  assign run = (|drv_en_reg) && clk_ok && rate_ok; // RULE8 RULE14

  // output stage; mono reuses the left boost so the bridged pair matches
  always_comb begin
    mono_next = speaker_mode_strap; // RULE1
    lg_out_next = lboost_reg;
    rg_out_next = mono_reg ? lboost_reg : rboost_reg; // RULE3
    len_next = drv_en_reg[LEN_BIT] && clk_ok && rate_ok; // RULE11
    ren_next = drv_en_reg[REN_BIT] && clk_ok && rate_ok; // RULE11
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= GAP_LIMIT;
      mono_reg <= 1'b0;
      lg_out_reg <= BOOST_RST;
      rg_out_reg <= BOOST_RST;
      len_reg <= 1'b0;
      ren_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      mono_reg <= mono_next;
      lg_out_reg <= lg_out_next;
      rg_out_reg <= rg_out_next;
      len_reg <= len_next;
      ren_reg <= ren_next;
    end
  end

  assign mode_strap_pullup_en = pullup_reg;
  assign mono_mode = mono_reg;
  assign left_boost_gain = lg_out_reg;
  assign right_boost_gain = rg_out_reg;
  assign left_output_en = len_reg;
  assign right_output_en = ren_reg;

  // switching clock toggles every n/2 ticks of the audio system clock
  scd_clk_div u_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick(system_clock_tick),
    .run(run),
    .half(div_n[5:1]),
    .clk_out(switch_clk)
  ); // RULE7

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  strap_follow_a: assert property (resetn |=> mono_mode == $past(speaker_mode_strap)) // RULE1
    else $error("mono mode does not follow strap");
  pullup_write_a: assert property (wr_en && idx == IDX_PULL |=> mode_strap_pullup_en == $past(pwdata[PU_BIT])) // RULE2
    else $error("pull-up bit not written");
  mono_gain_a: assert property (mono_mode |=> right_boost_gain == left_boost_gain) // RULE3
    else $error("mono right gain differs from left");
  lboost_write_a: assert property (wr_en && idx == IDX_BOOST |=> ##1 left_boost_gain == $past(pwdata[5:3], 2)) // RULE4
    else $error("left boost not applied");
  rboost_write_a: assert property (wr_en && idx == IDX_BOOST ##1 !mono_mode |=> right_boost_gain == $past(pwdata[2:0], 2)) // RULE5
    else $error("right boost not applied");
  tick_toggle_a: assert property ($changed(switch_clk) |-> $past(system_clock_tick) || !$past(run)) // RULE7
    else $error("switch clock moved without a tick");
  run_enable_a: assert property ($rose(switch_clk) |-> $past(|drv_en_reg)) // RULE8
    else $error("switch clock rose with drivers off");
  src_two_a: assert property (src_reg && sr2_reg == SR_96K && rt2_reg == 3'h0 |-> div_n == 6'h20) // RULE9
    else $error("second interface rate not used");
  clock_loss_a: assert property (!clk_ok |=> !left_output_en && !right_output_en) // RULE11
    else $error("outputs on without clock");
  fsw_441_a: assert property (sel_sr == SR_44K1 && sel_rt == 3'h2 |-> fsw == FSW_352K8 && div_n == 6'h20) // RULE12
    else $error("44.1k ratio 256 divide wrong");
  fsw_8k_a: assert property (sel_sr == SR_8K && sel_rt == 3'h4 |-> fsw == FSW_341K3 && div_n == 6'h0c) // RULE13
    else $error("8k ratio 512 divide wrong");
  fsw_16k_a: assert property (sel_sr == SR_16K && sel_rt == 3'h3 |-> fsw == FSW_384K && div_n == 6'h10) // RULE13
    else $error("16k ratio 384 divide wrong");
  stop_idle_a: assert property (!run |=> !switch_clk) // RULE14
    else $error("switch clock not stopped");

  cov_mono_run: cover property (mono_mode && run && $rose(switch_clk));
  cov_clock_loss: cover property (run ##1 !clk_ok);
  cov_stereo_run: cover property (left_output_en && right_output_en && !mono_mode);

endmodule
`default_nettype wire

// File: src/scd_pkg.sv
// shared constants and types for the speaker switching clock control block
package scd_pkg;

  // clock timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CLK_GAP_NS = 1000;
  localparam int CLK_GAP_CYC = (CLK_GAP_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] GAP_LIMIT = 8'(CLK_GAP_CYC);

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_DRV_EN = 12'h001;
  localparam logic [11:0] IDX_CLK_SRC = 12'h002;
  localparam logic [11:0] IDX_STATUS = 12'h003;
  localparam logic [11:0] IDX_IF1_RATE = 12'h010;
  localparam logic [11:0] IDX_IF2_RATE = 12'h011;
  localparam logic [11:0] IDX_BOOST = 12'h025;
  localparam logic [11:0] IDX_PULL = 12'h721;

  // field positions
  localparam int LB_MSB = 5;
  localparam int LB_LSB = 3;
  localparam int RB_MSB = 2;
  localparam int RB_LSB = 0;
  localparam int PU_BIT = 1;
  localparam int LEN_BIT = 0;
  localparam int REN_BIT = 1;
  localparam int SRC_BIT = 0;
  localparam int SR_MSB = 3;
  localparam int SR_LSB = 0;
  localparam int RT_MSB = 6;
  localparam int RT_LSB = 4;

  // reset values
  localparam logic [2:0] BOOST_RST = 3'h0;
  localparam logic PULL_RST = 1'b1;
  localparam logic [1:0] DRV_EN_RST = 2'h0;
  localparam logic SRC_RST = 1'b0;
  localparam logic [3:0] SR_RST = 4'h8;
  localparam logic [2:0] RT_RST = 3'h2;

  // sample rate codes
  localparam logic [3:0] SR_8K = 4'h0;
  localparam logic [3:0] SR_11K025 = 4'h1;
  localparam logic [3:0] SR_12K = 4'h2;
  localparam logic [3:0] SR_16K = 4'h3;
  localparam logic [3:0] SR_22K05 = 4'h4;
  localparam logic [3:0] SR_24K = 4'h5;
  localparam logic [3:0] SR_32K = 4'h6;
  localparam logic [3:0] SR_44K1 = 4'h7;
  localparam logic [3:0] SR_48K = 4'h8;
  localparam logic [3:0] SR_88K2 = 4'h9;
  localparam logic [3:0] SR_96K = 4'ha;

  // ratio codes 0..7 = 128,192,256,384,512,768,1024,1536

  typedef enum logic [2:0] {
    FSW_OFF = 3'b000,
    FSW_256K = 3'b001,
    FSW_341K3 = 3'b010,
    FSW_352K8 = 3'b011,
    FSW_384K = 3'b100
  } scd_fsw_t;

endpackage

// File: src/scd_clk_div.sv
// divider that turns audio system clock ticks into the switching clock
`timescale 1ns/100ps
`default_nettype none
module scd_clk_div import scd_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [4:0] half,
  output logic clk_out
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic out_reg;
  logic out_next;

  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!run) begin
      cnt_next = 5'h00;
      out_next = 1'b0;
    end else if (tick) begin
      // >= so a ratio change mid-count cannot overrun the terminal value
      if (cnt_reg >= 5'(half - 5'h01)) begin
        cnt_next = 5'h00;
        out_next = ~out_reg;
      end else begin
        cnt_next = 5'(cnt_reg + 5'h01);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 5'h00;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;

endmodule
`default_nettype wire

// File: test/scd_spk_model.sv
// speaker board model: strap wiring and switching clock measurement
`timescale 1ns/100ps
`default_nettype none
module scd_spk_model (
  input wire logic clk_sys,
  input wire logic [1:0] strap_cfg,
  input wire logic mode_strap_pullup_en,
  input wire logic switch_clk,
  output logic speaker_mode_strap,
  output int period,
  output int hi_len,
  output int edges
);
  int cnt = 0;
  int hcnt = 0;
  int ecnt = 0;
  logic prev = 1'b0;
  logic flt = 1'b0;
  assign edges = ecnt;
  // an open pin without pull-up is noise, never a held level
  always_comb begin
    case (strap_cfg)
      2'h0: speaker_mode_strap = 1'b0;
      2'h1: speaker_mode_strap = 1'b1;
      default: speaker_mode_strap = mode_strap_pullup_en ? 1'b1 : flt;
    endcase
  end
  always @(posedge clk_sys) begin
    flt <= ~flt;
    prev <= switch_clk;
    cnt <= cnt + 1;
    if (switch_clk) hcnt <= hcnt + 1;
    if (switch_clk && !prev) begin
      period <= cnt;
      cnt <= 1;
      ecnt <= ecnt + 1;
    end
    if (!switch_clk && prev) begin
      hi_len <= hcnt;
      hcnt <= 0;
    end
  end
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the speaker switching clock control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import scd_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, system_clock_tick = 1'b0, tick_on = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] strap_cfg = 2'h2;
  logic pready, pslverr, re, speaker_mode_strap, mode_strap_pullup_en, mono_mode, s;
  logic [2:0] left_boost_gain, right_boost_gain;
  logic left_output_en, right_output_en, switch_clk;
  logic [5:0] b;
  int period, hi_len, edges, e0, c, failures = 0, tests_run = 0, cycles = 0, acc = 0;

  scd_ctrl i_scd_ctrl (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .speaker_mode_strap(speaker_mode_strap),
    .system_clock_tick(system_clock_tick), .mode_strap_pullup_en(mode_strap_pullup_en), .mono_mode(mono_mode),
    .left_boost_gain(left_boost_gain), .right_boost_gain(right_boost_gain),
    .left_output_en(left_output_en), .right_output_en(right_output_en), .switch_clk(switch_clk));
  scd_spk_model i_scd_spk_model (.clk_sys(clk_sys), .strap_cfg(strap_cfg),
    .mode_strap_pullup_en(mode_strap_pullup_en), .switch_clk(switch_clk),
    .speaker_mode_strap(speaker_mode_strap), .period(period), .hi_len(hi_len), .edges(edges));

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) system_clock_tick <= tick_on;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end

  function automatic int fs_hz(int sr);
    int t[11] = '{8000, 11025, 12000, 16000, 22050, 24000, 32000, 44100, 48000, 88200, 96000};
    return t[sr];
  endfunction
  function automatic int ratio(int rt);
    return (rt % 2 ? 192 : 128) << (rt / 2);
  endfunction
  function automatic int exp_code(int sr, int rt);
    int f;
    f = fs_hz(sr);
    if (f * ratio(rt) > 12288000) return 0;
    if (f % 11025 == 0) return 3;
    if (f == 8000) return (rt % 2 == 0 && rt > 0) ? 2 : 1;
    if (f == 16000 || f == 32000) return rt % 2 ? 4 : 2;
    return 4;
  endfunction
  // ticks come every cycle, so one switching period is this many clk_sys cycles
  function automatic int exp_n(int sr, int rt);
    int hz[5] = '{0, 256000, 0, 352800, 384000};
    if (exp_code(sr, rt) == 2) return fs_hz(sr) * ratio(rt) * 3 / 1024000;
    return fs_hz(sr) * ratio(rt) / hz[exp_code(sr, rt)];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    acc = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one cycle
    do begin
      @(posedge clk_sys);
      acc++;
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    xfer(1'b1, {2'h0, i, 2'h0}, d);
  endtask
  task automatic rd(input logic [11:0] i);
    xfer(1'b0, {2'h0, i, 2'h0}, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h48ba));
    idle(20);
    resetn <= 1'b1;
    idle(3);
    chk("pullup_en", 1, mode_strap_pullup_en);
    chk("mono_float", 1, mono_mode);
    rd(IDX_PULL);
    chk("acc_cycles", 1, acc);
    chk("pull_reg", 32'h2, rv & 32'h2);
    rd(IDX_BOOST);
    chk("boost_rst", 0, rv & 32'h3f);
    foreach (paddr[i]) if (i < 2) begin
      xfer(1'b0, i ? 16'h0200 : 16'h0096, 32'h0);
      chk("slverr", 1, re);
      chk("bad_rd", 0, rv);
    end
    wr(IDX_PULL, 32'h0);
    idle(2);
    chk("pullup_off", 0, mode_strap_pullup_en);
    wr(IDX_PULL, 32'h2);
    idle(2);
    chk("pullup_on", 1, mode_strap_pullup_en);
    strap_cfg <= 2'h0;
    idle(3);
    chk("stereo", 0, mono_mode);
    for (int i = 0; i < 16; i++) begin
      b = (i < 8) ? {i[2:0], ~i[2:0]} : 6'($urandom);
      wr(IDX_BOOST, {26'h0, b});
      idle(2);
      chk("left_gain", b[5:3], left_boost_gain);
      chk("right_gain", b[2:0], right_boost_gain);
      rd(IDX_BOOST);
      chk("boost_reg", b, rv & 32'h3f);
    end
    strap_cfg <= 2'h1;
    wr(IDX_BOOST, 32'h3a);
    idle(3);
    chk("mono", 1, mono_mode);
    chk("mono_right", 3'h7, right_boost_gain);
    tick_on <= 1'b1;
    wr(IDX_DRV_EN, 32'h3);
    for (int sr = 0; sr < 11; sr++) begin
      for (int rt = 0; rt < 8; rt++) begin
        // 96k/128 always through the second interface so that path is seen
        s = (sr == 10 && rt == 0) ? 1'b1 : 1'($urandom);
        wr(s ? IDX_IF1_RATE : IDX_IF2_RATE, 32'($urandom) & 32'h7f);
        wr(s ? IDX_IF2_RATE : IDX_IF1_RATE, {25'h0, 3'(rt), 4'(sr)});
        wr(IDX_CLK_SRC, {31'h0, s});
        c = exp_code(sr, rt);
        idle(c ? 4 * exp_n(sr, rt) + 8 : 40);
        rd(IDX_STATUS);
        chk("freq_code", c, {29'h0, rv[6:4]});
        chk("left_en", c != 0, left_output_en);
        if (c != 0) begin
          chk("period", exp_n(sr, rt), period);
          chk("hi_len", exp_n(sr, rt) / 2, hi_len);
        end else begin
          e0 = edges;
          idle(40);
          chk("halted", e0, edges);
        end
      end
    end
    strap_cfg <= 2'h0;
    wr(IDX_IF1_RATE, 32'h28);
    wr(IDX_CLK_SRC, 32'h0);
    wr(IDX_DRV_EN, 32'h2);
    idle(80);
    chk("right_only", 1, right_output_en);
    chk("left_off", 0, left_output_en);
    chk("period_r", 32, period);
    wr(IDX_DRV_EN, 32'h0);
    idle(10);
    e0 = edges;
    idle(100);
    chk("idle_edges", e0, edges);
    chk("idle_low", 0, switch_clk);
    wr(IDX_DRV_EN, 32'h3);
    idle(40);
    tick_on <= 1'b0;
    idle(GAP_LIMIT - 20);
    chk("gap_short", 1, left_output_en);
    idle(40);
    chk("lost_l", 0, left_output_en);
    chk("lost_r", 0, right_output_en);
    e0 = edges;
    rd(IDX_STATUS);
    chk("present", 0, rv[1]);
    chk("lost_edges", e0, edges);
    tick_on <= 1'b1;
    idle(60);
    chk("back", 1, left_output_en);
    conclude();
  end
endmodule
`default_nettype wire
